// *** sac_params.svh ***
// named offsets, bit positions, reset values and counts for the converter control
// assumes: included by its bare name, before use, by every design file that uses its macros
`ifndef SAC_PARAMS_SVH
`define SAC_PARAMS_SVH

// ----------------------------------------
// register byte offsets on apb
// ----------------------------------------
`define SAC_ADDR_W       12
`define SAC_OFS_CTRL     12'h000
`define SAC_OFS_CFG      12'h004
`define SAC_OFS_RES_HI   12'h008
`define SAC_OFS_RES_LO   12'h00C
`define SAC_OFS_CHAN     12'h010
`define SAC_OFS_PAIR     12'h014

// ----------------------------------------
// reset values
// ----------------------------------------
`define SAC_CTRL_RST     8'h00
`define SAC_CFG_RST      8'hF8
`define SAC_CHAN_RST     4'h0
`define SAC_PAIR_RST     4'h0
`define SAC_RES_RST      8'h00

// ----------------------------------------
// sizes and counts
// ----------------------------------------
`define SAC_RES_BITS     10
`define SAC_DIV_BITS     5
`define SAC_CONV_CLKS    16
`define SAC_TRACK_LAST   2'h2
`define SAC_TEMP_BIT     3
`define SAC_LJ_PAD       6'h00

`endif

// *** sac_pkg.sv ***
// types shared by the converter control and its helpers
// assumes: sac_params.svh is on the include path
package sac_pkg;

  // ----------------------------------------
  // sequencer states and start sources
  // ----------------------------------------
  typedef enum logic [3:0] {
    SAC_ST_IDLE  = 4'b0001,
    SAC_ST_TRACK = 4'b0010,
    SAC_ST_CONV  = 4'b0100,
    SAC_ST_DONE  = 4'b1000
  } sac_state_t;

  typedef enum logic [1:0] {
    SAC_CM_WRITE = 2'b00,
    SAC_CM_TMR3  = 2'b01,
    SAC_CM_PIN   = 2'b10,
    SAC_CM_TMR2  = 2'b11
  } sac_start_mode_t;

  // ----------------------------------------
  // register layouts, msb first
  // ----------------------------------------
  typedef struct packed {
    logic            converter_enable_bit;
    logic            track_mode_bit;
    logic            conversion_done_flag;
    logic            conversion_busy_bit;
    sac_start_mode_t start_mode;
    logic            window_flag;
    logic            left_justify_select;
  } sac_ctrl_t;

  typedef struct packed {
    logic [4:0] clock_divider_field;
    logic [2:0] gain_select_field;
  } sac_cfg_t;

  // ----------------------------------------
  // analog front-end controls
  // ----------------------------------------
  typedef struct packed {
    logic       power;
    logic       track;
    logic       convert;
    logic       temp_sel;
    logic [3:0] channel_address_field;
    logic [3:0] pair_config;
    logic [2:0] gain_select_field;
    logic [9:0] dac;
  } sac_analog_t;

endpackage

// *** sac_clkdiv.sv ***
// conversion clock enable derived from the system clock
// assumes: run is low whenever no sequence is in progress
`timescale 1ns/10ps
`include "sac_params.svh"
module sac_clkdiv #(
  parameter int DIV_W = `SAC_DIV_BITS
) (
  // clock and reset
  input  wire logic             sys_clk_i,
  input  wire logic             rst_n_i,
  // control
  input  wire logic             run_i,
  input  wire logic [DIV_W-1:0] div_i,
  // enable pulse
  output logic                  tick_o
);
  logic [DIV_W:0] cnt_reg;
  wire  [DIV_W:0] limit = {div_i, 1'b1};
  wire            bypass = (div_i == '0);
  wire            wrap = (cnt_reg == limit);

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i || !run_i) begin
      cnt_reg <= '0;
      tick_o  <= 1'b0;
    end else begin
      cnt_reg <= (wrap || bypass) ? '0 : cnt_reg + 1'b1;
      tick_o  <= wrap || bypass;
    end
  end
endmodule

// *** sac_sar.sv ***
// bitwise successive-approximation engine, one decision per conversion tick
// assumes: cmp_i is high when the held input is at or above the trial level
`timescale 1ns/10ps
`include "sac_params.svh"
module sac_sar #(
  parameter int RES_W     = `SAC_RES_BITS,
  parameter int CONV_CLKS = `SAC_CONV_CLKS
) (
  // clock and reset
  input  wire logic             sys_clk_i,
  input  wire logic             rst_n_i,
  // sequencing
  input  wire logic             start_i,
  input  wire logic             tick_i,
  input  wire logic             cmp_i,
  // trial level and result
  output logic      [RES_W-1:0] trial_o,
  output logic                  done_o
);
  localparam int CW = $clog2(CONV_CLKS);
  logic [RES_W-1:0] mask_reg;
  logic [CW-1:0]    cnt_reg;
  logic             run_reg;
  wire              last = (cnt_reg == CW'(CONV_CLKS - 1));
  wire [RES_W-1:0]  kept = cmp_i ? trial_o : (trial_o & ~mask_reg);

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      trial_o  <= '0;
      mask_reg <= '0;
      cnt_reg  <= '0;
      run_reg  <= 1'b0;
      done_o   <= 1'b0;
    end else if (start_i) begin
      trial_o  <= {1'b1, {(RES_W-1){1'b0}}};
      mask_reg <= {1'b1, {(RES_W-1){1'b0}}};
      cnt_reg  <= '0;
      run_reg  <= 1'b1;
      done_o   <= 1'b0;
    end else if (run_reg && tick_i) begin
      // remaining ticks after the last bit pad out the conversion time
      if (mask_reg != '0) begin
        trial_o  <= kept | (mask_reg >> 1);
        mask_reg <= mask_reg >> 1;
      end
      cnt_reg <= cnt_reg + 1'b1;
      run_reg <= !last;
      done_o  <= last;
    end else begin
      done_o <= 1'b0;
    end
  end
endmodule

// *** sac_conv_ctrl.sv ***
// control logic of the 10-bit successive-approximation converter, apb slave
// assumes: timer overflows are one-cycle pulses on sys_clk_i; analog front end outside
`timescale 1ns/10ps
`include "sac_params.svh"
module sac_conv_ctrl #(
  parameter int RES_W     = `SAC_RES_BITS,
  parameter int CONV_CLKS = `SAC_CONV_CLKS
) (
  // clock and reset
  input  wire logic                      sys_clk_i,
  input  wire logic                      rst_n_i,
  // apb slave
  input  wire logic                      psel_i,
  input  wire logic                      penable_i,
  input  wire logic                      pwrite_i,
  input  wire logic [`SAC_ADDR_W-1:0]    paddr_i,
  input  wire logic [31:0]               pwdata_i,
  output logic      [31:0]               prdata_o,
  output logic                           pready_o,
  output logic                           pslverr_o,
  // start sources and chip state
  input  wire logic                      tmr3_ovf_i,
  input  wire logic                      tmr2_ovf_i,
  input  wire logic                      external_start_pin_i,
  input  wire logic                      standby_i,
  // analog front end
  input  wire logic                      cmp_i,
  output sac_pkg::sac_analog_t           analog_o,
  // status
  output logic                           conv_irq_o,
  output logic                           busy_o
);
  import sac_pkg::*;

  // ----------------------------------------
  // apb address decode
  // ----------------------------------------
  function automatic logic [5:0] sac_decode(input logic [`SAC_ADDR_W-1:0] a);
    logic [5:0] hit;
    hit = 6'h00;
    if (a == `SAC_OFS_CTRL) begin
      hit = 6'h01;
    end else if (a == `SAC_OFS_CFG) begin
      hit = 6'h02;
    end else if (a == `SAC_OFS_RES_HI) begin
      hit = 6'h04;
    end else if (a == `SAC_OFS_RES_LO) begin
      hit = 6'h08;
    end else if (a == `SAC_OFS_CHAN) begin
      hit = 6'h10;
    end else if (a == `SAC_OFS_PAIR) begin
      hit = 6'h20;
    end
    return hit;
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  sac_ctrl_t        ctrl_reg;
  sac_ctrl_t        ctrl_next;
  sac_cfg_t         cfg_reg;
  logic [3:0]       chan_reg;
  logic [3:0]       pair_reg;
  logic [7:0]       res_hi_reg;
  logic [7:0]       res_lo_reg;
  sac_state_t       state_reg;
  sac_state_t       state_next;
  logic [1:0]       trk_cnt_reg;
  logic             pin_s1_reg;
  logic             pin_s2_reg;
  logic             pin_s3_reg;
  logic             track_reg;
  logic             power_reg;
  logic             conv_reg;
  logic [3:0]       chan_out_reg;
  logic [3:0]       pair_out_reg;
  logic [2:0]       gain_out_reg;
  logic             tick;
  logic             sar_done;
  logic [RES_W-1:0] sar_val;

  // ----------------------------------------
  // apb transfer qualifiers
  // ----------------------------------------
  wire [5:0]      sel      = sac_decode(paddr_i);
  wire            setup    = psel_i & ~penable_i;
  wire            wr_fire  = psel_i & penable_i & pready_o & pwrite_i & ~pslverr_o;
  wire            wr_ctrl  = wr_fire & sel[0];
  wire            wr_cfg   = wr_fire & sel[1];
  wire            wr_chan  = wr_fire & sel[4];
  wire            wr_pair  = wr_fire & sel[5];
  wire sac_ctrl_t wr_val   = sac_ctrl_t'(pwdata_i[7:0]);
  wire [7:0]      rd_byte  = sel[0] ? 8'(ctrl_reg) :
                             sel[1] ? 8'(cfg_reg) :
                             sel[2] ? res_hi_reg :
                             sel[3] ? res_lo_reg :
                             sel[4] ? {4'h0, chan_reg} :
                             sel[5] ? {4'h0, pair_reg} : 8'h00;

  // ----------------------------------------
  // start source selection
  // ----------------------------------------
  sac_start_mode_t cm;
  assign cm = ctrl_reg.start_mode;
  wire enabled  = ctrl_reg.converter_enable_bit;
  wire low_pwr  = ctrl_reg.track_mode_bit;
  wire idle     = (state_reg == SAC_ST_IDLE);
  wire pin_rise = pin_s2_reg & ~pin_s3_reg;
  wire pin_low  = ~pin_s2_reg;
  wire sw_start = wr_ctrl & wr_val.conversion_busy_bit & (cm == SAC_CM_WRITE);
  wire trig     = (cm == SAC_CM_WRITE) ? sw_start :
                  (cm == SAC_CM_TMR3)  ? tmr3_ovf_i :
                  (cm == SAC_CM_PIN)   ? pin_rise : tmr2_ovf_i;
  // a start while tracking or converting is dropped, not queued
  wire start_ok = trig & enabled & idle;
  wire go_track = low_pwr & (cm != SAC_CM_PIN);
  wire trk_end  = tick & (trk_cnt_reg == `SAC_TRACK_LAST);
  wire in_seq   = (state_reg == SAC_ST_TRACK) | (state_reg == SAC_ST_CONV);
  wire sar_go   = (state_reg != SAC_ST_CONV) & (state_next == SAC_ST_CONV);
  wire busy_clr = (state_reg == SAC_ST_DONE) | ~enabled;
  wire busy_fall = ctrl_reg.conversion_busy_bit & busy_clr;

  // ----------------------------------------
  // result justification
  // ----------------------------------------
  wire       temp_ch = chan_out_reg[`SAC_TEMP_BIT];
  wire       diff    = ~temp_ch & pair_out_reg[chan_out_reg[2:1]];
  wire       sgn     = diff & sar_val[RES_W-1];
  wire [7:0] rj_hi   = {{6{sgn}}, sar_val[9:8]};
  wire [7:0] lj_lo   = {sar_val[1:0], `SAC_LJ_PAD};
  wire [7:0] hi_val  = ctrl_reg.left_justify_select ? sar_val[9:2] : rj_hi;
  wire [7:0] lo_val  = ctrl_reg.left_justify_select ? lj_lo : sar_val[7:0];
  wire       res_wr  = sar_done & (state_reg == SAC_ST_CONV);

  // ----------------------------------------
  // tracking decision
  // ----------------------------------------
  wire trk_lp   = (state_reg == SAC_ST_TRACK) | (idle & (cm == SAC_CM_PIN) & pin_low);
  wire trk_want = low_pwr ? trk_lp : idle;
  wire trk_next = enabled & ~standby_i & trk_want;

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SAC_ST_IDLE: begin
        if (start_ok) begin
          state_next = go_track ? SAC_ST_TRACK : SAC_ST_CONV;
        end
      end
      SAC_ST_TRACK: begin
        if (trk_end) begin
          state_next = SAC_ST_CONV;
        end
      end
      SAC_ST_CONV: begin
        if (sar_done) begin
          state_next = SAC_ST_DONE;
        end
      end
      SAC_ST_DONE: begin
        state_next = SAC_ST_IDLE;
      end
      default: begin
        state_next = SAC_ST_IDLE;
      end
    endcase
    if (!enabled) begin
      state_next = SAC_ST_IDLE;
    end
  end

  // ----------------------------------------
  // control register next value
  // ----------------------------------------
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl) begin
      ctrl_next = wr_val;
      // busy is owned by the sequencer, writing 0 does nothing
      ctrl_next.conversion_busy_bit = ctrl_reg.conversion_busy_bit;
      ctrl_next.window_flag = 1'b0;
    end
    if (start_ok) begin
      ctrl_next.conversion_busy_bit = 1'b1;
    end else if (busy_clr) begin
      ctrl_next.conversion_busy_bit = 1'b0;
    end
    // hardware set wins over a clear in the same cycle
    if (busy_fall) begin
      ctrl_next.conversion_done_flag = 1'b1;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      ctrl_reg <= sac_ctrl_t'(`SAC_CTRL_RST);
      cfg_reg  <= sac_cfg_t'(`SAC_CFG_RST);
      chan_reg <= `SAC_CHAN_RST;
      pair_reg <= `SAC_PAIR_RST;
    end else begin
      ctrl_reg <= ctrl_next;
      if (wr_cfg) begin
        cfg_reg <= sac_cfg_t'(pwdata_i[7:0]);
      end
      if (wr_chan) begin
        chan_reg <= pwdata_i[3:0];
      end
      if (wr_pair) begin
        pair_reg <= pwdata_i[3:0];
      end
    end
  end

  // mux and gain settings only move while nothing is in flight
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      chan_out_reg <= `SAC_CHAN_RST;
      pair_out_reg <= `SAC_PAIR_RST;
      gain_out_reg <= 3'h0;
    end else if (!ctrl_reg.conversion_busy_bit) begin
      chan_out_reg <= chan_reg;
      pair_out_reg <= pair_reg;
      gain_out_reg <= cfg_reg.gain_select_field;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      res_hi_reg <= `SAC_RES_RST;
      res_lo_reg <= `SAC_RES_RST;
    end else if (res_wr) begin
      res_hi_reg <= hi_val;
      res_lo_reg <= lo_val;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      state_reg   <= SAC_ST_IDLE;
      trk_cnt_reg <= 2'h0;
    end else begin
      state_reg   <= state_next;
      trk_cnt_reg <= (state_reg != SAC_ST_TRACK) ? 2'h0 : trk_cnt_reg + 2'(tick);
    end
  end

  // ----------------------------------------
  // pin synchroniser
  // ----------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      pin_s1_reg <= 1'b1; // pin idles high, no false edge after reset
      pin_s2_reg <= 1'b1;
      pin_s3_reg <= 1'b1;
    end else begin
      pin_s1_reg <= external_start_pin_i;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
    end
  end

  // ----------------------------------------
  // analog controls and status outputs
  // ----------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      power_reg  <= 1'b0;
      track_reg  <= 1'b0;
      conv_reg   <= 1'b0;
      busy_o     <= 1'b0;
      conv_irq_o <= 1'b0;
    end else begin
      power_reg  <= enabled;
      track_reg  <= trk_next;
      conv_reg   <= (state_next == SAC_ST_CONV);
      busy_o     <= ctrl_next.conversion_busy_bit;
      conv_irq_o <= ctrl_next.conversion_done_flag;
    end
  end

  assign analog_o.power                 = power_reg;
  assign analog_o.track                 = track_reg;
  assign analog_o.convert               = conv_reg;
  assign analog_o.temp_sel              = chan_out_reg[`SAC_TEMP_BIT];
  assign analog_o.channel_address_field = chan_out_reg;
  assign analog_o.pair_config           = pair_out_reg;
  assign analog_o.gain_select_field     = gain_out_reg;
  assign analog_o.dac                   = sar_val;

  // ----------------------------------------
  // apb answer, one wait-free access cycle
  // ----------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end else begin
      pready_o  <= setup;
      pslverr_o <= setup & (sel == 6'h00);
      prdata_o  <= (setup && !pwrite_i) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // conversion clock and sar engine
  // ----------------------------------------
  sac_clkdiv #(
    .DIV_W (`SAC_DIV_BITS)
  ) u_clkdiv (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .run_i     (in_seq & enabled),
    .div_i     (cfg_reg.clock_divider_field),
    .tick_o    (tick)
  );

  // 16 ticks at the slowest divider is 1024 cycles, well inside 10 us
  sac_sar #(
    .RES_W     (RES_W),
    .CONV_CLKS (CONV_CLKS)
  ) u_sar (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .start_i   (sar_go),
    .tick_i    (tick),
    .cmp_i     (cmp_i),
    .trial_o   (sar_val),
    .done_o    (sar_done)
  );

endmodule

// *** sac_front_model.sv ***
// comparator and sample-and-hold stand-in for the converter front end
// assumes: the bench supplies the analog level as a 10-bit code
`timescale 1ns/10ps
module sac_front_model import sac_pkg::*; (
  // clock
  input  wire logic        sys_clk_i,
  // front end controls and level
  input  wire sac_analog_t analog_i,
  input  wire logic [9:0]  level_i,
  // comparator
  output logic             cmp_o
);
  logic [9:0] held_reg = 10'h000;
  logic       chat_reg = 1'h0;

  always_ff @(posedge sys_clk_i) begin
    chat_reg <= ~chat_reg;
    if (analog_i.power && analog_i.track) begin
      held_reg <= level_i;
    end
  end

  // unpowered comparator chatters, so no stable answer leaks out
  assign cmp_o = analog_i.power ? (held_reg >= analog_i.dac) : chat_reg;
endmodule

// *** sac_conv_ctrl_monitor.sv ***
// assertion checker for the converter control ports
// assumes: bound onto sac_conv_ctrl, one clock domain
`timescale 1ns/10ps
`include "sac_params.svh"
module sac_conv_ctrl_monitor import sac_pkg::*; #(
  parameter int RES_W     = `SAC_RES_BITS,
  parameter int CONV_CLKS = `SAC_CONV_CLKS
) (
  // clock and reset
  input wire logic                   sys_clk_i,
  input wire logic                   rst_n_i,
  // apb
  input wire logic                   psel_i,
  input wire logic                   penable_i,
  input wire logic                   pwrite_i,
  input wire logic [`SAC_ADDR_W-1:0] paddr_i,
  input wire logic [31:0]            pwdata_i,
  input wire logic [31:0]            prdata_o,
  input wire logic                   pready_o,
  input wire logic                   pslverr_o,
  // sources and front end
  input wire logic                   tmr3_ovf_i,
  input wire logic                   tmr2_ovf_i,
  input wire logic                   external_start_pin_i,
  input wire logic                   standby_i,
  input wire logic                   cmp_i,
  input wire sac_analog_t            analog_o,
  input wire logic                   conv_irq_o,
  input wire logic                   busy_o
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  wire             ctrl_wr = psel_i && penable_i && pwrite_i && pready_o && paddr_i == `SAC_OFS_CTRL;
  wire             clr_wr  = ctrl_wr && !pwdata_i[5];
  wire             idle_on = analog_o.power && !busy_o;
  sac_start_mode_t mode_reg;
  sac_start_mode_t mode_next;

  // shadow of the start mode, so start checks know the selected source
  assign mode_next = ctrl_wr ? sac_start_mode_t'(pwdata_i[3:2]) : mode_reg;
  always_ff @(posedge sys_clk_i) begin
    mode_reg <= rst_n_i ? mode_next : SAC_CM_WRITE;
  end

  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_power_gate: assert property (!analog_o.power |-> !analog_o.track && !analog_o.convert)
    else $error("front end active while powered down");
  a_sw_start: assert property (ctrl_wr && pwdata_i[4] && mode_reg == SAC_CM_WRITE && idle_on |-> ##[1:3] busy_o)
    else $error("busy write did not start a conversion");
  a_sw_refused: assert property (ctrl_wr && pwdata_i[4] && mode_reg != SAC_CM_WRITE && idle_on |-> ##1 !busy_o [*3])
    else $error("busy write started a conversion in a timer or pin mode");
  a_tmr3_start: assert property (tmr3_ovf_i && mode_reg == SAC_CM_TMR3 && idle_on |-> ##[1:3] busy_o)
    else $error("timer 3 overflow did not start a conversion");
  a_tmr2_start: assert property (tmr2_ovf_i && mode_reg == SAC_CM_TMR2 && idle_on |-> ##[1:3] busy_o)
    else $error("timer 2 overflow did not start a conversion");
  a_busy_hold: assert property ($rose(busy_o) |-> busy_o [*8])
    else $error("busy dropped early");
  a_done_on_fall: assert property ($fell(busy_o) |-> conv_irq_o)
    else $error("completion flag not set as busy fell");
  a_flag_sticky: assert property ($fell(conv_irq_o) |-> $past(clr_wr) || $past(clr_wr, 2))
    else $error("completion flag cleared without a software write");
  a_standby_track: assert property (standby_i [*3] |-> !analog_o.track)
    else $error("tracking during standby");
  a_mux_idle: assert property ($changed(analog_o.pair_config) |-> !$past(busy_o))
    else $error("pair setting changed during a conversion");

  c_done: cover property ($fell(busy_o));
  c_pin: cover property ($rose(busy_o) && mode_reg == SAC_CM_PIN);
  c_err: cover property (pslverr_o);
endmodule

bind sac_conv_ctrl sac_conv_ctrl_monitor #(.RES_W(RES_W), .CONV_CLKS(CONV_CLKS)) u_monitor (
  .sys_clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
  .pslverr_o, .tmr3_ovf_i, .tmr2_ovf_i, .external_start_pin_i, .standby_i, .cmp_i, .analog_o,
  .conv_irq_o, .busy_o);

// *** test_sac_conv_ctrl.sv ***
// self-checking bench for the converter control over apb
// assumes: sac_front_model answers the comparator; bench drives timers and pin
`timescale 1ns/10ps
`include "sac_params.svh"
module test_sac_conv_ctrl;
  import sac_pkg::*;
  logic        sys_clk_i            = 1'h0;
  logic        rst_n_i              = 1'h0;
  logic        psel_i               = 1'h0;
  logic        penable_i            = 1'h0;
  logic        pwrite_i             = 1'h0;
  logic [11:0] paddr_i              = 12'h000;
  logic [31:0] pwdata_i             = 32'h0;
  logic        tmr3_ovf_i           = 1'h0;
  logic        tmr2_ovf_i           = 1'h0;
  logic        external_start_pin_i = 1'h1;
  logic        standby_i            = 1'h0;
  logic        cmp_i;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  logic        conv_irq_o;
  logic        busy_o;
  sac_analog_t analog_o;
  logic [9:0]  level                = 10'h000;
  logic [33:0] exp_q[$];
  logic [31:0] ctl;
  logic [1:0]  md;
  logic        tm;
  logic        lj;
  int          dv;
  int          n;
  int          nt;
  int          num_errors           = 0;
  int          check_count          = 0;
  int          seed                 = 11366;
  int          cycles               = 0;

  sac_conv_ctrl dut (.sys_clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
    .pready_o, .pslverr_o, .tmr3_ovf_i, .tmr2_ovf_i, .external_start_pin_i, .standby_i, .cmp_i, .analog_o,
    .conv_irq_o, .busy_o);
  sac_front_model u_front (.sys_clk_i, .analog_i(analog_o), .level_i(level), .cmp_o(cmp_i));

  initial begin
    forever #2 sys_clk_i = ~sys_clk_i;
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // holds the request until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [33:0] e);
    exp_q.push_back(e);
    @(posedge sys_clk_i);
    psel_i   <= 1'h1;
    pwrite_i <= wr;
    paddr_i  <= a;
    pwdata_i <= d;
    @(posedge sys_clk_i);
    penable_i <= 1'h1;
    do @(posedge sys_clk_i); while (pready_o !== 1'h1);
    psel_i    <= 1'h0;
    penable_i <= 1'h0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'h1, a, d, {2'h0, 32'h0});
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic err);
    apb(1'h0, a, 32'h0, {1'h1, err, x});
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Test passed");
    end
    else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // oldest note is taken off as each answer appears
  always @(posedge sys_clk_i) begin
    logic [33:0] e;
    if (psel_i && penable_i && pready_o === 1'h1) begin
      e = exp_q.pop_front();
      check("pslverr", 32'(e[32]), 32'(pslverr_o));
      if (e[33]) begin
        check("prdata", e[31:0], prdata_o);
      end
    end
  end

  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      print_verdict();
    end
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge sys_clk_i);
    rst_n_i <= 1'h1;
    rd(`SAC_OFS_CTRL, 32'(`SAC_CTRL_RST), 1'h0);
    rd(`SAC_OFS_CFG, 32'(`SAC_CFG_RST), 1'h0);
    rd(`SAC_OFS_RES_HI, 32'(`SAC_RES_RST), 1'h0);
    rd(`SAC_OFS_PAIR, 32'(`SAC_PAIR_RST), 1'h0);
    rd(12'h018, 32'h0, 1'h1);
    @(negedge sys_clk_i);
    check("gain", 32'h0, 32'(analog_o.gain_select_field));
    wr(`SAC_OFS_CHAN, 32'hFD);
    wr(`SAC_OFS_PAIR, 32'hFA);
    rd(`SAC_OFS_CHAN, 32'hD, 1'h0);
    rd(`SAC_OFS_PAIR, 32'hA, 1'h0);
    @(negedge sys_clk_i);
    check("temp_sel", 32'h1, 32'(analog_o.temp_sel));
    check("channel", 32'hD, 32'(analog_o.channel_address_field));
    check("pair", 32'hA, 32'(analog_o.pair_config));
    wr(`SAC_OFS_PAIR, 32'h0);
    wr(`SAC_OFS_CHAN, 32'h5);
    $display("register test done");
    wr(`SAC_OFS_CFG, 32'h0);
    wr(`SAC_OFS_CTRL, 32'h84);
    wr(`SAC_OFS_CTRL, 32'h94);
    @(posedge sys_clk_i);
    tmr2_ovf_i <= 1'h1;
    @(posedge sys_clk_i);
    tmr2_ovf_i <= 1'h0;
    repeat (6) @(negedge sys_clk_i);
    check("busy", 32'h0, 32'(busy_o));
    $display("refusal test done");
    for (int i = 0; i < 8; i++) begin
      md    = 2'(i);
      tm    = i[2];
      lj    = i[1] ^ i[2];
      dv    = i % 3;
      ctl   = {24'h0, 1'h1, tm, 2'h0, md, 1'h0, lj};
      level <= 10'($random(seed));
      wr(`SAC_OFS_PAIR, {29'h0, i[0], 2'h0});
      wr(`SAC_OFS_CFG, {24'h0, 5'(dv), 3'(i)});
      repeat (2) @(negedge sys_clk_i);
      check("gain", 32'(i[2:0]), 32'(analog_o.gain_select_field));
      wr(`SAC_OFS_CTRL, ctl);
      if (md == 2'h0) begin
        wr(`SAC_OFS_CTRL, ctl | 32'h10);
      end
      else begin
        @(posedge sys_clk_i);
        external_start_pin_i <= (md != 2'h2);
        repeat (12) @(posedge sys_clk_i);
        if (md == 2'h2) begin
          check("track", 32'h1, 32'(analog_o.track));
        end
        tmr3_ovf_i           <= (md == 2'h1);
        tmr2_ovf_i           <= (md == 2'h3);
        external_start_pin_i <= 1'h1;
        @(posedge sys_clk_i);
        tmr3_ovf_i <= 1'h0;
        tmr2_ovf_i <= 1'h0;
      end
      n = 0;
      while (busy_o !== 1'h1 && n < 60) begin
        @(negedge sys_clk_i);
        n++;
      end
      n = 0;
      while (busy_o === 1'h1 && n < 400) begin
        @(negedge sys_clk_i);
        n++;
      end
      nt = ((tm && md != 2'h2) ? 19 : 16) * ((dv == 0) ? 1 : 2 * (dv + 1));
      check("busy cycles", 32'h1, 32'(n >= nt - 3 && n <= nt + 4));
      check("conv_irq", 32'h1, 32'(conv_irq_o));
      rd(`SAC_OFS_CTRL, ctl | 32'h20, 1'h0);
      rd(`SAC_OFS_RES_HI, lj ? 32'(level[9:2]) : 32'({{6{i[0] & level[9]}}, level[9:8]}), 1'h0);
      rd(`SAC_OFS_RES_LO, lj ? 32'({level[1:0], 6'h00}) : 32'(level[7:0]), 1'h0);
      $display("conversion %0d done", i);
    end
    wr(`SAC_OFS_CTRL, 32'h80);
    @(negedge sys_clk_i);
    check("conv_irq", 32'h0, 32'(conv_irq_o));
    @(negedge sys_clk_i);
    check("track", 32'h1, 32'(analog_o.track));
    @(posedge sys_clk_i);
    standby_i <= 1'h1;
    repeat (4) @(negedge sys_clk_i);
    check("track", 32'h0, 32'(analog_o.track));
    wr(`SAC_OFS_CTRL, 32'h0);
    repeat (2) @(negedge sys_clk_i);
    check("power", 32'h0, 32'(analog_o.power));
    $display("power test done");
    print_verdict();
  end
endmodule
